//--- verilog/rfct_top.sv
// RF front-end strobe timing with APB register access
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
module rfct_top
    import rfct_pkg::*;
#(
    parameter int STEP_CYCLES = STEP_CYC
) (
    input wire logic pclk,                 // APB and system clock
    input wire logic presetn,              // Asynchronous reset, low
    input wire logic psel,                 // APB select
    input wire logic penable,              // APB access phase
    input wire logic pwrite,               // APB write
    input wire logic [ADDR_W-1:0] paddr,   // APB byte address
    input wire logic [31:0] pwdata,        // APB write data
    output logic [31:0] prdata,            // APB read data
    output logic pready,                   // APB ready
    output logic pslverr,                  // APB error, unmapped
    input wire rfct_fmt_evt_t fmt,         // Formatter frame events
    input wire logic rx_indep_mode,        // Independent receive timing
    output logic tx_bit_start,             // Start first tx bit, pulse
    output logic tx_rf_strobe,             // Transmit enable pin
    output logic rx_rf_strobe,             // Receive enable pin
    output logic aux_rf_strobe,            // Auxiliary strobe pin
    input wire logic gpio_ten_out,         // Port value for pin ten
    input wire logic gpio_ten_oe,          // Port enable for pin ten
    output logic general_pin_ten_out,      // Pin ten output
    output logic general_pin_ten_oe,       // Pin ten output enable
    input wire logic ext_irq_pin_two_in,   // Irq pin two level
    output logic ext_irq_pin_two_out,      // Irq pin two output
    output logic ext_irq_pin_two_oe,       // Irq pin two output enable
    output logic ext_irq_two               // Synced irq level
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] tx_rf_timing;
    logic [7:0] rx_rf_timing;
    logic [3:0] rf_strobe_polarity;
    logic [3:0] rx_fall_offset;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire hit_tx = (paddr == rfct_addr(IDX_TX_TIMING));
    wire hit_rx = (paddr == rfct_addr(IDX_RX_TIMING));
    wire hit_pol = (paddr == rfct_addr(IDX_POLARITY));
    wire hit_fall = (paddr == rfct_addr(IDX_RX_FALL));
    wire hit_stat = (paddr == rfct_addr(IDX_STATUS));
    wire hit_any = hit_tx | hit_rx | hit_pol | hit_fall | hit_stat;
    wire setup_rd = psel && !penable && !pwrite;
    wire wr_en = psel && penable && pwrite && pready;

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_any;

    // ------------------------------------------------------------
    // Strobe state, shown in the status register
    // ------------------------------------------------------------
    rfct_strobe_t act;

    // Read mux; reserved bits read zero
    logic [7:0] next_rdata;
    assign next_rdata =
        hit_tx ? tx_rf_timing :
        hit_rx ? rx_rf_timing :
        hit_pol ? {4'h0, rf_strobe_polarity} :
        hit_fall ? {4'h0, rx_fall_offset} :
        hit_stat ? {4'h0, act.tx, act.rx, act.aux, act.ant} :
        8'h00;

    // Read data latched in the setup cycle, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata <= {24'h00_0000, next_rdata};
        end
    end

    // Register writes; status is read only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_rf_timing <= RST_TX_TIMING;
            rx_rf_timing <= RST_RX_TIMING;
            rf_strobe_polarity <= RST_POLARITY;
            rx_fall_offset <= RST_RX_FALL;
        end else if (wr_en) begin
            if (hit_tx) tx_rf_timing <= pwdata[7:0];
            if (hit_rx) rx_rf_timing <= pwdata[7:0];
            if (hit_pol) rf_strobe_polarity <= pwdata[3:0];
            if (hit_fall) rx_fall_offset <= pwdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // Code decode
    // ------------------------------------------------------------
    // Invalid codes saturate at the last valid one rather than overflow
    wire [3:0] tx_lead_delay = (tx_rf_timing[7:4] > TX_LEAD_MAX) ?
        TX_LEAD_MAX : tx_rf_timing[7:4];
    wire [3:0] tx_lag_code = (tx_rf_timing[3:0] > TX_LAG_MAX) ?
        TX_LAG_MAX : tx_rf_timing[3:0];
    wire [4:0] rx_lead_delay = (rx_rf_timing[4:0] > RX_LEAD_MAX) ?
        RX_LEAD_MAX : rx_rf_timing[4:0];
    wire [3:0] rx_fall_to_tx_time = rx_fall_offset;
    wire slicer_en = rx_rf_timing[RX_SLICER_BIT];
    wire ant_sel = rx_rf_timing[RX_ANT_SEL_BIT];
    wire rx_strobe_force = rx_rf_timing[RX_FORCE_BIT];

    // Reference 32.1 us ahead of the first bit: wait code steps
    rfct_delay_t tx_lead_dly;
    assign tx_lead_dly.steps = STEP_W'(tx_lead_delay);
    assign tx_lead_dly.rem = '0;

    // Lag of 4.3 us plus code steps after the last bit
    rfct_delay_t tx_lag_dly;
    assign tx_lag_dly.steps = rfct_split_ns(TX_LAG_BASE_NS).steps
        + STEP_W'(tx_lag_code);
    assign tx_lag_dly.rem = rfct_split_ns(TX_LAG_BASE_NS).rem;

    // Reference 87.6 us ahead of first rx bit; top code starts at once
    rfct_delay_t rx_lead_dly;
    wire rx_lead_top = (rx_lead_delay == RX_LEAD_MAX);
    assign rx_lead_dly.steps = rx_lead_top ? '0 :
        rfct_split_ns(RX_REF_NS - RX_LEAD_BASE_NS).steps
        - STEP_W'(rx_lead_delay);
    assign rx_lead_dly.rem = rx_lead_top ? '0 :
        rfct_split_ns(RX_REF_NS - RX_LEAD_BASE_NS).rem;

    // Table values are not evenly spaced, so split each one
    rfct_delay_t fbt_dly;
    assign fbt_dly = rfct_split_ns(FBT_NS[rx_fall_to_tx_time]);

    // Receive slot reference source
    wire rx_ref = rx_indep_mode ? fmt.rx_ref_recovered
                                : fmt.rx_ref_locked;

    // ------------------------------------------------------------
    // Transmit strobe sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_LEAD = 2'b01,
        TX_ON = 2'b11,
        TX_LAG = 2'b10
    } rfct_tx_state_t;

    rfct_tx_state_t tx_state;
    rfct_tx_state_t next_tx_state;
    logic tx_dly_done;
    logic tx_dly_start;
    rfct_delay_t tx_dly_sel;

    // Formatter going idle abandons the frame at once
    always_comb begin
        next_tx_state = tx_state;
        tx_dly_start = 1'b0;
        tx_dly_sel = tx_lead_dly;
        case (tx_state)
            TX_IDLE: begin
                if (fmt.active && fmt.tx_ref) begin
                    next_tx_state = TX_LEAD;
                    tx_dly_start = 1'b1;
                end
            end
            TX_LEAD: begin
                if (tx_dly_done) next_tx_state = TX_ON;
            end
            TX_ON: begin
                if (fmt.tx_last_bit) begin
                    next_tx_state = TX_LAG;
                    tx_dly_start = 1'b1;
                    tx_dly_sel = tx_lag_dly;
                end
            end
            TX_LAG: begin
                if (tx_dly_done) next_tx_state = TX_IDLE;
            end
            default: next_tx_state = TX_IDLE;
        endcase
        if (!fmt.active) next_tx_state = TX_IDLE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= TX_IDLE;
        end else begin
            tx_state <= next_tx_state;
        end
    end

    rfct_delay #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_tx_delay (
        .pclk(pclk),
        .presetn(presetn),
        .start(tx_dly_start),
        .abort(!fmt.active),
        .delay(tx_dly_sel),
        .done(tx_dly_done)
    );

    // ------------------------------------------------------------
    // Receive strobe sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_LEAD = 2'b01,
        RX_ON = 2'b11,
        RX_FBT = 2'b10
    } rfct_rx_state_t;

    rfct_rx_state_t rx_state;
    rfct_rx_state_t next_rx_state;
    logic rx_dly_done;
    logic rx_dly_start;
    rfct_delay_t rx_dly_sel;
    logic next_tx_bit_start;

    // After the strobe falls, independent mode times the first tx bit
    always_comb begin
        next_rx_state = rx_state;
        rx_dly_start = 1'b0;
        rx_dly_sel = rx_lead_dly;
        next_tx_bit_start = 1'b0;
        case (rx_state)
            RX_IDLE: begin
                if (fmt.active && rx_ref) begin
                    next_rx_state = RX_LEAD;
                    rx_dly_start = 1'b1;
                end
            end
            RX_LEAD: begin
                if (rx_dly_done) next_rx_state = RX_ON;
            end
            RX_ON: begin
                if (fmt.rx_last_bit && rx_indep_mode) begin
                    next_rx_state = RX_FBT;
                    rx_dly_start = 1'b1;
                    rx_dly_sel = fbt_dly;
                end else if (fmt.rx_last_bit) begin
                    next_rx_state = RX_IDLE;
                end
            end
            RX_FBT: begin
                if (rx_dly_done) begin
                    next_rx_state = RX_IDLE;
                    next_tx_bit_start = 1'b1;
                end
            end
            default: next_rx_state = RX_IDLE;
        endcase
        if (!fmt.active) next_rx_state = RX_IDLE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= RX_IDLE;
            tx_bit_start <= 1'b0;
        end else begin
            rx_state <= next_rx_state;
            tx_bit_start <= next_tx_bit_start && fmt.active;
        end
    end

    rfct_delay #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_rx_delay (
        .pclk(pclk),
        .presetn(presetn),
        .start(rx_dly_start),
        .abort(!fmt.active),
        .delay(rx_dly_sel),
        .done(rx_dly_done)
    );

    // ------------------------------------------------------------
    // Active levels of the strobes
    // ------------------------------------------------------------
    // Force keeps the receiver open for level scans while idle
    assign act.tx = (tx_state == TX_ON) || (tx_state == TX_LAG);
    assign act.rx = (rx_state == RX_ON) || rx_strobe_force;
    assign act.aux = (rx_state == RX_ON);
    assign act.ant = act.tx;

    // ------------------------------------------------------------
    // Pin sync and output stage
    // ------------------------------------------------------------
    logic irq_meta;

    // Two flops before anything reads the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_meta <= 1'b0;
            ext_irq_two <= 1'b0;
        end else begin
            irq_meta <= ext_irq_pin_two_in;
            ext_irq_two <= irq_meta;
        end
    end

    // Polarity applied in the last flop keeps the pins glitch free
    rfct_strobe_t pin;
    assign pin.tx = act.tx ^ rf_strobe_polarity[POL_TX_BIT];
    assign pin.rx = act.rx ^ rf_strobe_polarity[POL_RX_BIT];
    assign pin.aux = act.aux ^ rf_strobe_polarity[POL_AUX_BIT];
    assign pin.ant = act.ant ^ rf_strobe_polarity[POL_ANT_BIT];

    // Pin ten carries the slicer strobe or the port value
    wire next_ten_out = slicer_en ? pin.aux : gpio_ten_out;
    wire next_ten_oe = slicer_en | gpio_ten_oe;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_rf_strobe <= 1'b0;
            rx_rf_strobe <= 1'b0;
            aux_rf_strobe <= 1'b0;
            general_pin_ten_out <= 1'b0;
            general_pin_ten_oe <= 1'b0;
            ext_irq_pin_two_out <= 1'b0;
            ext_irq_pin_two_oe <= 1'b0;
        end else begin
            tx_rf_strobe <= pin.tx;
            rx_rf_strobe <= pin.rx;
            aux_rf_strobe <= pin.aux;
            general_pin_ten_out <= next_ten_out;
            general_pin_ten_oe <= next_ten_oe;
            ext_irq_pin_two_out <= pin.ant;
            ext_irq_pin_two_oe <= ant_sel;
        end
    end

endmodule : rfct_top

//--- verilog/rfct_pkg.sv
// Shared constants, types and helpers of the RF control timing block
package rfct_pkg;

    // ------------------------------------------------------------
    // Clock and timebase
    // ------------------------------------------------------------
    localparam int CLK_NS = 8;
    localparam int STEP_NS = 3470;
    // One step of the internal timebase, rounded down to whole cycles
    localparam int STEP_CYC = STEP_NS / CLK_NS;
    localparam int STEP_W = 5;
    localparam int REM_W = 9;

    // ------------------------------------------------------------
    // Register map (printed offsets are word indices)
    // ------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam logic [15:0] IDX_TX_TIMING = 16'hFFD4;
    localparam logic [15:0] IDX_RX_TIMING = 16'hFFD5;
    localparam logic [15:0] IDX_POLARITY = 16'hFFD8;
    localparam logic [15:0] IDX_RX_FALL = 16'hFFD9;
    localparam logic [15:0] IDX_STATUS = 16'hFFDB;

    localparam logic [7:0] RST_TX_TIMING = 8'h8B;
    localparam logic [7:0] RST_RX_TIMING = 8'h0B;
    localparam logic [3:0] RST_POLARITY = 4'h0;
    localparam logic [3:0] RST_RX_FALL = 4'h0;

    // Field positions of the receive timing register
    localparam int RX_SLICER_BIT = 7;
    localparam int RX_ANT_SEL_BIT = 6;
    localparam int RX_FORCE_BIT = 5;
    // Polarity bit positions
    localparam int POL_TX_BIT = 3;
    localparam int POL_RX_BIT = 2;
    localparam int POL_AUX_BIT = 1;
    localparam int POL_ANT_BIT = 0;

    // ------------------------------------------------------------
    // Delay codes and times
    // ------------------------------------------------------------
    localparam logic [3:0] TX_LEAD_MAX = 4'h9;
    localparam logic [3:0] TX_LAG_MAX = 4'hC;
    localparam logic [4:0] RX_LEAD_MAX = 5'h16;
    localparam int TX_LAG_BASE_NS = 4300;
    localparam int RX_LEAD_BASE_NS = 11300;
    // Reference pulse of the receive slot leads the first bit by this
    localparam int RX_REF_NS = 87600;
    localparam int FBT_NS [16] = '{54700, 51200, 47700, 44300,
                                   40800, 37300, 33900, 30400,
                                   26900, 23400, 20000, 16500,
                                   13000, 9500, 6900, 2600};

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic active;           // Formatter running
        logic tx_ref;           // Transmit slot reference, 32.1 us early
        logic tx_last_bit;      // Last transmitted bit sent
        logic rx_ref_locked;    // Receive reference tied to tx frame
        logic rx_ref_recovered; // Receive reference from recovered clock
        logic rx_last_bit;      // Last received bit taken
    } rfct_fmt_evt_t;

    typedef struct packed {
        logic tx;
        logic rx;
        logic aux;
        logic ant;
    } rfct_strobe_t;

    typedef struct packed {
        logic [STEP_W-1:0] steps;
        logic [REM_W-1:0] rem;
    } rfct_delay_t;

    // Splits a time into whole steps plus a residue in cycles
    function automatic rfct_delay_t rfct_split_ns(input int ns);
        rfct_delay_t d;
        d.steps = STEP_W'(ns / STEP_NS);
        d.rem = REM_W'((ns % STEP_NS) / CLK_NS);
        return d;
    endfunction : rfct_split_ns

    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] rfct_addr(input logic [15:0] idx);
        return {idx, 2'b00};
    endfunction : rfct_addr

endpackage : rfct_pkg

//--- verilog/rfct_delay.sv
// Programmable delay counter on the 3.47 us step timebase
`timescale 1ns/1ns
module rfct_delay
    import rfct_pkg::*;
#(
    parameter int STEP_CYCLES = STEP_CYC
) (
    input wire logic pclk,           // System clock
    input wire logic presetn,        // Asynchronous reset, active low
    input wire logic start,          // Load the delay and start
    input wire logic abort,          // Drop a running delay
    input wire rfct_delay_t delay,   // Steps and residue to wait
    output logic done                // One-cycle pulse at expiry
);

    // ------------------------------------------------------------
    // Residue first, then whole steps
    // ------------------------------------------------------------
    logic busy;
    logic [REM_W-1:0] cyc;
    logic [STEP_W-1:0] steps_left;
    wire cyc_zero = (cyc == '0);

    // Step divider restarts on load so no phase jitter enters the delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            cyc <= '0;
            steps_left <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy <= 1'b0;
            end else if (start) begin
                busy <= 1'b1;
                cyc <= delay.rem;
                steps_left <= delay.steps;
            end else if (busy && !cyc_zero) begin
                cyc <= cyc - 1'b1;
            end else if (busy && steps_left != '0) begin
                cyc <= REM_W'(STEP_CYCLES - 1);
                steps_left <= steps_left - 1'b1;
            end else if (busy) begin
                busy <= 1'b0;
                done <= 1'b1;
            end
        end
    end

endmodule : rfct_delay

//--- bench/rfct_props.sv
// Port assertions of the RF control timing block
`timescale 1ns/1ns
module rfct_props
    import rfct_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access
    input wire logic pwrite, // APB write
    input wire logic [ADDR_W-1:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire rfct_fmt_evt_t fmt, // Formatter events
    input wire logic rx_indep_mode, // Independent rx timing
    input wire logic tx_bit_start, // First tx bit pulse
    input wire logic rx_rf_strobe, // Receive strobe pin
    input wire logic aux_rf_strobe, // Aux strobe pin
    input wire logic gpio_ten_out, // Port value, pin ten
    input wire logic general_pin_ten_out, // Pin ten drive
    input wire logic ext_irq_pin_two_in, // Pin two level
    input wire logic ext_irq_pin_two_oe, // Pin two enable
    input wire logic ext_irq_two // Synced pin two
);
    // ------------------------------------------------------------
    // Shadow copies of the written controls
    // ------------------------------------------------------------
    logic [7:0] rxt;
    logic [3:0] pol;
    wire acc = psel && penable && pready;
    wire [15:0] idx = paddr[17:2];
    wire mapped = idx inside {IDX_TX_TIMING, IDX_RX_TIMING, IDX_POLARITY,
                              IDX_RX_FALL, IDX_STATUS};
    wire rx_on = rx_rf_strobe != pol[POL_RX_BIT];
    // Only accepted writes move the shadows, as in the device
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxt <= RST_RX_TIMING;
            pol <= RST_POLARITY;
        end else if (acc && pwrite && idx == IDX_RX_TIMING) begin
            rxt <= pwdata[7:0];
        end else if (acc && pwrite && idx == IDX_POLARITY) begin
            pol <= pwdata[3:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence force_held;
        (rxt[RX_FORCE_BIT] && $stable(pol)) [*2];
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    apb_ready_a: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    slave_err_a: assert property (psel && penable |-> pslverr == !mapped)
        else $error("error flag does not match the map");
    read_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 0 &&
        (idx != IDX_RX_FALL || prdata[7:4] == 4'h0))
        else $error("reserved read bits not zero");
    force_rx_a: assert property (force_held |-> rx_on)
        else $error("forced receive strobe not active");
    rx_fall_a: assert property (fmt.rx_last_bit && rx_on &&
        !rxt[RX_FORCE_BIT] |-> ##3 !rx_on)
        else $error("receive strobe did not fall");
    pin_gpio_a: assert property (!rxt[RX_SLICER_BIT] [*2] |->
        general_pin_ten_out == $past(gpio_ten_out))
        else $error("pin ten does not follow its port");
    pin_aux_a: assert property ((rxt[RX_SLICER_BIT] &&
        $stable(aux_rf_strobe)) [*3] |-> general_pin_ten_out == aux_rf_strobe)
        else $error("pin ten does not carry the aux strobe");
    ant_oe_a: assert property (rxt[RX_ANT_SEL_BIT] [*2] |-> ext_irq_pin_two_oe)
        else $error("pin two not driven as antenna output");
    irq_sync_a: assert property (ext_irq_pin_two_in [*2] |=> ext_irq_two)
        else $error("pin two level not passed on");
    bit_start_a: assert property (tx_bit_start |-> rx_indep_mode ##1
        !tx_bit_start)
        else $error("first bit pulse out of mode or too long");
endmodule : rfct_props

bind rfct_top rfct_props u_props (.*);

//--- bench/rfct_radio.sv
// Behavioural front end on pin two: antenna input or interrupt source
`timescale 1ns/1ns
module rfct_radio (
    input wire logic irq_req, // Interrupt level the source raises
    input wire logic pin_out, // Device drive of pin two
    input wire logic pin_oe, // Device enable of pin two
    output logic pin_wire // Resolved level of pin two
);
    // Source yields the wire while the device drives it
    assign pin_wire = pin_oe ? pin_out : irq_req;
endmodule : rfct_radio

//--- bench/rf_control_timing_tb.sv
// Self-checking testbench of the RF control timing block
`timescale 1ns/1ns
module rf_control_timing_tb import rfct_pkg::*;;
    // Short timebase step keeps the runs brief
    localparam int STEP = 4;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, rx_indep_mode = 0, irq_req = 0;
    logic gpio_ten_out = 0, gpio_ten_oe = 0, tx_bit_start, tx_rf_strobe;
    logic rx_rf_strobe, aux_rf_strobe, general_pin_ten_out;
    logic general_pin_ten_oe, ext_irq_pin_two_in, ext_irq_pin_two_out;
    logic ext_irq_pin_two_oe, ext_irq_two;
    rfct_fmt_evt_t fmt = '0;
    logic [3:0] lead [3] = '{4'h0, 4'h9, 4'hF};
    logic [3:0] lag [3] = '{4'h0, 4'hC, 4'h5};
    int fail_count = 0, num_checks = 0, cycles = 0, n = 0, ns = 0;

    rfct_top #(.STEP_CYCLES(STEP)) i_dut (.*);
    rfct_radio i_radio (.irq_req, .pin_out(ext_irq_pin_two_out),
        .pin_oe(ext_irq_pin_two_oe), .pin_wire(ext_irq_pin_two_in));

    // ------------------------------------------------------------
    // Clock, reset and hang guard
    // ------------------------------------------------------------
    initial forever #4 pclk = ~pclk;
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        if (fail_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task automatic check(input string what, input logic [31:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // One APB transfer; held until ready is seen at an edge
    task automatic apb(input logic wr, input logic [15:0] idx,
                       input logic [31:0] wd);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask : settle
    function automatic logic probe(input int w);
        case (w)
            0: return tx_rf_strobe;
            1: return rx_rf_strobe;
            default: return tx_bit_start;
        endcase
    endfunction : probe
    // Pulse one event, then count edges until the output reaches lvl
    task automatic pulse_wait(input int bitn, input int w, input logic lvl);
        @(posedge pclk);
        fmt[bitn] <= 1'b1;
        @(posedge pclk);
        fmt[bitn] <= 1'b0;
        #1;
        n = 0;
        while (probe(w) !== lvl && n < 3000) begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask : pulse_wait

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        @(posedge presetn);
        apb(0, IDX_TX_TIMING, 0);
        check("tx_rf_timing", 32'h0000008B, rd);
        apb(0, IDX_RX_TIMING, 0);
        check("rx_rf_timing", 32'h0000000B, rd);
        apb(0, IDX_RX_FALL, 0);
        check("rx_fall_offset", 32'h00000000, rd);
        apb(1, IDX_RX_FALL, 32'h000000FF);
        apb(0, IDX_RX_FALL, 0);
        check("rx_fall_offset", 32'h0000000F, rd);
        apb(0, 16'hFFD7, 0);
        check("pslverr", 32'h1, err);
        // Idle level of each strobe, antenna strobe seen on pin two
        apb(1, IDX_RX_TIMING, 32'h0000004B);
        for (int i = 0; i < 5; i++) begin
            apb(1, IDX_POLARITY, 32'h1 << i);
            settle();
            check("tx_rf_strobe", i == 3, tx_rf_strobe);
            check("rx_rf_strobe", i == 2, rx_rf_strobe);
            check("aux_rf_strobe", i == 1, aux_rf_strobe);
            check("pin two", i == 0, ext_irq_pin_two_in);
        end
        apb(1, IDX_RX_TIMING, 32'h0000000B);
        @(posedge pclk);
        irq_req <= 1'b1;
        gpio_ten_out <= 1'b1;
        gpio_ten_oe <= 1'b1;
        settle();
        check("ext_irq_pin_two_oe", 0, ext_irq_pin_two_oe);
        check("ext_irq_two", 1, ext_irq_two);
        check("pin ten", 32'h3, {general_pin_ten_oe, general_pin_ten_out});
        apb(1, IDX_RX_TIMING, 32'h0000008B);
        settle();
        check("pin ten", 0, general_pin_ten_out);
        apb(1, IDX_RX_TIMING, 32'h0000002B);
        settle();
        check("forced rx strobe", 1, rx_rf_strobe);
        apb(1, IDX_RX_TIMING, 32'h0000000B);
        settle();
        check("released rx strobe", 0, rx_rf_strobe);
        // Transmit lead and lag, invalid lead saturating
        @(posedge pclk);
        fmt.active <= 1'b1;
        rx_indep_mode <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1, IDX_TX_TIMING, {24'h0, lead[i], lag[i]});
            pulse_wait(4, 0, 1'b1);
            check("tx lead", (lead[i] > 9 ? 9 : lead[i]) * STEP + 3, n);
            pulse_wait(3, 0, 1'b0);
            check("tx lag", (lag[i] + 1) * STEP + 106, n);
        end
        // Independent mode: recovered reference, then first tx bit
        for (int c = 0; c < 16; c += 15) begin
            apb(1, IDX_RX_FALL, c);
            pulse_wait(1, 1, 1'b1);
            check("rx strobe up", 1, rx_rf_strobe);
            pulse_wait(0, 2, 1'b1);
            ns = FBT_NS[c];
            check("first tx bit", ns / STEP_NS * STEP +
                ns % STEP_NS / CLK_NS + 2, n);
        end
        stop_test();
    end
endmodule : rf_control_timing_tb
